/* File: logic/page_stack_defs.svh */
// constants of the page context stack: register indexes, field
// positions and reset values.
// assumes it is included by bare name from the design files and the bench.
`ifndef PAGE_STACK_DEFS_SVH
`define PAGE_STACK_DEFS_SVH

// ************************************************************
// register indexes (byte address is four times the index)
// ************************************************************
`define REG_IDX_CTRL 8'h84
`define REG_IDX_MIDDLE 8'h85
`define REG_IDX_ACTIVE 8'hA6
`define REG_IDX_BOTTOM 8'hA7

// ************************************************************
// address split and field layout
// ************************************************************
`define IDX_LSB 2
`define IDX_MSB 9
`define PAGE_MSB 7
`define CTRL_AUTO_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define PAGE_RESET 8'h00
// only the automatic paging bit is kept, and it comes up set
`define CTRL_RESET 1'h1
`define READ_ZERO 32'h0000_0000

`endif

/* File: logic/page_stack_pkg.sv */
// types shared by the page context stack and its register front end.
// assumes nothing of its surroundings.
package page_stack_pkg;
   // one byte of page context
   typedef logic [7:0] page_t;
   // which stack entry a software write lands on
   typedef enum logic [1:0] {
      SEL_NONE = 2'b00,
      SEL_ACTIVE = 2'b01,
      SEL_MIDDLE = 2'b11,
      SEL_BOTTOM = 2'b10
   } entry_sel_t;
endpackage

/* File: logic/page_stack_if.sv */
// carrier between the register front end and the stack storage.
// assumes both ends run on the same clock.
`timescale 1ns/1ns
interface page_stack_if;
   import page_stack_pkg::*;
   logic push; // interrupt entry, one cycle
   logic pop; // return from interrupt, one cycle
   logic auto_load; // load the interrupt page on push
   page_t push_page; // page of the interrupting source
   logic wr_en; // accepted software write
   entry_sel_t wr_sel; // entry written
   page_t wr_data; // byte written
   page_t active; // top entry
   page_t middle; // second entry
   page_t bottom; // third entry
   modport ctrl (
      output push, pop, auto_load, push_page, wr_en, wr_sel, wr_data,
      input active, middle, bottom
   );
   modport stack (
      input push, pop, auto_load, push_page, wr_en, wr_sel, wr_data,
      output active, middle, bottom
   );
endinterface // page_stack_if

/* File: logic/page_stack_core.sv */
// storage of the three-entry page context stack.
// assumes push, pop and writes are single-cycle pulses on clk.
`timescale 1ns/1ns
`include "page_stack_defs.svh"
module page_stack_core (
   input wire logic clk,
   input wire logic rst_n,
   page_stack_if.stack stk
);
   import page_stack_pkg::*;

   // ************************************************************
   // stack entries
   // ************************************************************
   page_t active; // top, the page the core uses
   page_t middle; // second entry
   page_t bottom; // third entry
   page_t next_active;
   page_t next_middle;
   page_t next_bottom;

   assign stk.active = active;
   assign stk.middle = middle;
   assign stk.bottom = bottom;

   // next entries: hardware shift first, software write on top of it;
   // a write therefore wins for its own entry in a shared cycle
   always_comb begin
      next_active = active;
      next_middle = middle;
      next_bottom = bottom;
      if (stk.push) begin
         next_middle = active;
         next_bottom = middle;
         if (stk.auto_load) begin
            next_active = stk.push_page;
         end
      end else if (stk.pop) begin
         next_active = middle;
         next_middle = bottom;
      end
      if (stk.wr_en) begin
         case (stk.wr_sel)
            SEL_ACTIVE: next_active = stk.wr_data;
            SEL_MIDDLE: next_middle = stk.wr_data;
            SEL_BOTTOM: next_bottom = stk.wr_data;
            default: ;
         endcase
      end
   end

   // registers only; all entries clear on reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= `PAGE_RESET;
         middle <= `PAGE_RESET;
         bottom <= `PAGE_RESET;
      end else begin
         active <= next_active;
         middle <= next_middle;
         bottom <= next_bottom;
      end
   end
endmodule // page_stack_core

/* File: logic/sfr_page_context_stack.sv */
// page context stack with its Avalon-MM register front end.
// assumes irq_entry, irq_page and irq_return come from core logic on clk.
//
// What this block does
// - three byte levels: active, middle, bottom.
// - return copies bottom entry into middle.
// - writing bottom sets next middle after return.
// - reading bottom returns its current value.
// - direct accesses never push or pop.
// - only entry pushes, only return pops.
// - bottom is eight bits, read-write, resets zero.
// - bottom decoded independent of selected page.
// - auto paging loads interrupt page on entry.
// - return moves middle into active page.
// - auto paging off keeps active page.
`timescale 1ns/1ns
`include "page_stack_defs.svh"
module sfr_page_context_stack #(
   parameter int ADDR_W = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave, byte addresses, one register per word
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // core interrupt entry and return
   input wire logic irq_entry,
   input wire page_stack_pkg::page_t irq_page,
   input wire logic irq_return,
   output page_stack_pkg::page_t active_page,
   output logic auto_paging
);
   import page_stack_pkg::*;

   // ************************************************************
   // address decode
   // ************************************************************

   // true when the word index of addr equals idx; the selected page
   // plays no part, so every register here is seen from all pages
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [7:0] idx);
      hit = (addr[`IDX_MSB:`IDX_LSB] == idx);
   endfunction

   logic hit_ctrl; // control register
   logic hit_middle; // second entry
   logic hit_active; // top entry
   logic hit_bottom; // third entry
   logic hit_any; // any mapped register

   always_comb begin
      hit_ctrl = hit(address, `REG_IDX_CTRL);
      hit_middle = hit(address, `REG_IDX_MIDDLE);
      hit_active = hit(address, `REG_IDX_ACTIVE);
      hit_bottom = hit(address, `REG_IDX_BOTTOM);
      hit_any = hit_ctrl | hit_middle | hit_active | hit_bottom;
   end

   // ************************************************************
   // handshake: every access answers after exactly one wait cycle
   // ************************************************************
   logic next_waitrequest;
   logic wr_acc; // write takes effect at this edge

   // waitrequest rests high; a new request drops it for one cycle, and
   // it rises again at the completing edge so a held request is not
   // taken twice
   always_comb begin
      next_waitrequest = 1'b1;
      if ((read | write) & waitrequest) begin
         next_waitrequest = 1'b0;
      end
   end

   // only the low byte lane carries data; other lanes are ignored
   assign wr_acc = write & ~waitrequest & byteenable[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= next_waitrequest;
      end
   end

   // ************************************************************
   // stack storage
   // ************************************************************
   page_stack_if stk ();

   page_stack_core u_core (
      .clk(clk),
      .rst_n(rst_n),
      .stk(stk.stack)
   );

   // hardware events reach the stack unchanged; register accesses
   // only drive the write port, never push or pop
   always_comb begin
      stk.push = irq_entry;
      stk.pop = irq_return;
      stk.auto_load = auto_paging;
      stk.push_page = irq_page;
      stk.wr_en = wr_acc & (hit_active | hit_middle | hit_bottom);
      stk.wr_data = writedata[`PAGE_MSB:0];
      if (hit_active) begin
         stk.wr_sel = SEL_ACTIVE;
      end else if (hit_middle) begin
         stk.wr_sel = SEL_MIDDLE;
      end else if (hit_bottom) begin
         stk.wr_sel = SEL_BOTTOM;
      end else begin
         stk.wr_sel = SEL_NONE;
      end
   end

   // ************************************************************
   // control register and outputs
   // ************************************************************
   logic next_auto_paging;
   page_t next_active_page;

   // only the automatic paging bit is kept; the rest reads zero
   always_comb begin
      next_auto_paging = auto_paging;
      if (wr_acc & hit_ctrl) begin
         next_auto_paging = writedata[`CTRL_AUTO_BIT];
      end
      next_active_page = stk.active;
   end

   // active_page is a copy of the top entry, one cycle behind it, so
   // the output comes from a flop of this module
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_paging <= `CTRL_RESET;
         active_page <= `PAGE_RESET;
      end else begin
         auto_paging <= next_auto_paging;
         active_page <= next_active_page;
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   logic [31:0] next_readdata;

   // captured in the wait cycle; unmapped words read zero. a push in
   // the wait cycle is not seen by this read, a trade for a flop output
   always_comb begin
      next_readdata = readdata;
      if (read & waitrequest) begin
         next_readdata = `READ_ZERO;
         if (hit_ctrl) begin
            next_readdata[`CTRL_AUTO_BIT] = auto_paging;
         end else if (hit_middle) begin
            next_readdata[`PAGE_MSB:0] = stk.middle;
         end else if (hit_active) begin
            next_readdata[`PAGE_MSB:0] = stk.active;
         end else if (hit_bottom) begin
            next_readdata[`PAGE_MSB:0] = stk.bottom;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= `READ_ZERO;
      end else begin
         readdata <= next_readdata;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic quiet; // no hardware event this cycle
   assign quiet = ~irq_entry & ~irq_return;

   // push moves each level down one place
   a_push_shift: assert property (
      irq_entry & ~stk.wr_en |=>
      stk.middle == $past(stk.active) && stk.bottom == $past(stk.middle))
      else $error("push did not shift the stack");

   // two pushes one quiet cycle apart carry the top entry to the bottom
   a_three_levels: assert property (
      irq_entry & ~stk.wr_en ##1 quiet & ~stk.wr_en ##1 irq_entry & ~stk.wr_en |=>
      stk.bottom == $past(stk.active, 3))
      else $error("top entry did not reach bottom after two pushes");

   // return copies bottom into middle
   a_pop_bottom: assert property (
      irq_return & ~irq_entry & ~stk.wr_en |=>
      stk.middle == $past(stk.bottom))
      else $error("return did not copy bottom into middle");

   // return restores the saved page
   a_pop_restore: assert property (
      irq_return & ~irq_entry & ~stk.wr_en |=>
      stk.active == $past(stk.middle) ##1 active_page == $past(stk.middle, 2))
      else $error("return did not restore the active page");

   // written bottom value reaches middle at the next return
   a_bottom_reach: assert property (
      wr_acc & hit_bottom & quiet ##1 quiet & ~stk.wr_en ##1
      irq_return & ~irq_entry & ~stk.wr_en
      |=> stk.middle == $past(writedata[`PAGE_MSB:0], 3))
      else $error("written bottom value lost on return");

   // bottom read returns the stored byte, upper bits zero
   a_bottom_read: assert property (
      read & waitrequest & hit_bottom |=>
      readdata == {24'h00_0000, $past(stk.bottom)} && !waitrequest)
      else $error("bottom read returned a wrong value");

   // a write to middle touches only middle
   a_write_local: assert property (
      wr_acc & hit_middle & quiet |=>
      $stable(stk.active) && $stable(stk.bottom) &&
      stk.middle == $past(writedata[`PAGE_MSB:0]))
      else $error("entry write disturbed another entry");

   // without events or writes nothing moves
   a_no_shift: assert property (
      quiet & ~stk.wr_en |=>
      $stable(stk.active) && $stable(stk.middle) && $stable(stk.bottom))
      else $error("stack moved without an event");

   // bottom write stores all eight bits
   a_bottom_width: assert property (
      wr_acc & hit_bottom & quiet |=>
      stk.bottom == $past(writedata[`PAGE_MSB:0]))
      else $error("bottom write not stored");

   // bottom decode ignores the active page
   a_any_page: assert property (
      write & waitrequest & byteenable[0] & hit_bottom & quiet ##1
      quiet |=> stk.bottom == $past(writedata[`PAGE_MSB:0], 2))
      else $error("bottom write missed");

   // auto paging loads the interrupt page
   a_auto_load: assert property (
      irq_entry & auto_paging & ~stk.wr_en |=>
      stk.active == $past(irq_page))
      else $error("interrupt page not loaded");

   // auto paging off keeps the page
   a_manual_keep: assert property (
      irq_entry & ~auto_paging & ~stk.wr_en |=> $stable(stk.active))
      else $error("page changed with auto paging off");

   // every request answers after one wait cycle
   a_wait_one: assert property (
      (read | write) & waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest timing wrong");

   // unmapped reads give zero
   a_unmapped_zero: assert property (
      read & waitrequest & ~hit_any |=> readdata == `READ_ZERO)
      else $error("unmapped read not zero");

   // a return leaves the bottom entry as it was
   a_pop_keep_bottom: assert property (
      irq_return & ~irq_entry & ~stk.wr_en |=> $stable(stk.bottom))
      else $error("return changed the bottom entry");

   // a push in the same cycle as a return wins
   a_push_wins: assert property (
      irq_entry & irq_return & ~stk.wr_en |=> stk.bottom == $past(stk.middle))
      else $error("return beat a push in the same cycle");

   // the page port follows the top entry one cycle later
   a_page_follow: assert property (
      1'b1 |=> active_page == $past(stk.active))
      else $error("active page port lost the top entry");

   // a write with the low lane off changes nothing
   a_lane_off: assert property (
      write & ~waitrequest & ~byteenable[0] & quiet |=>
      $stable(stk.active) && $stable(stk.middle) && $stable(stk.bottom) &&
      $stable(auto_paging))
      else $error("write with low lane off took effect");

   // control write sets the automatic paging bit
   a_ctrl_write: assert property (
      wr_acc & hit_ctrl |=> auto_paging == $past(writedata[`CTRL_AUTO_BIT]))
      else $error("paging control bit not stored");

   // completed reads carry nothing above the page byte
   a_read_upper: assert property (
      read & ~waitrequest |-> readdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
endmodule // sfr_page_context_stack

/* File: verification/core_irq_model.sv */
// model of the core's interrupt entry and return strobes.
// assumes the bench calls pulse just after a rising edge of clk.
`timescale 1ns/1ns
module core_irq_model (
   input wire logic clk,
   output logic irq_entry,
   output page_stack_pkg::page_t irq_page,
   output logic irq_return
);
   import page_stack_pkg::*;
   // strobes idle from time zero; the page line starts at 5A
   initial begin
      irq_entry = 1'b0;
      irq_return = 1'b0;
      irq_page = 8'h5A;
   end
   // one-cycle strobe; the page line is then inverted so a stale page is never trusted
   task automatic pulse(input logic e, input logic r, input page_t p);
      @(posedge clk);
      irq_entry <= e;
      irq_return <= r;
      irq_page <= p;
      @(posedge clk);
      irq_entry <= 1'b0;
      irq_return <= 1'b0;
      irq_page <= ~p;
   endtask
endmodule // core_irq_model

/* File: verification/sfr_page_context_stack_bench.sv */
// self-checking bench of the page context stack.
// assumes the core model drives the event strobes and this bench the bus.
`timescale 1ns/1ns
`include "page_stack_defs.svh"
module sfr_page_context_stack_bench;
   import page_stack_pkg::*;
   // ************************************************************
   // signals and expected stack contents
   // ************************************************************
   logic clk;
   logic rst_n;
   logic [9:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq_entry;
   page_t irq_page;
   logic irq_return;
   page_t active_page;
   logic auto_paging;
   int fail_count;
   int n_compared;
   page_t e_act; // expected top entry
   page_t e_mid; // expected second entry
   page_t e_bot; // expected third entry
   logic e_auto; // expected paging control bit
   logic [9:0] reg_addr [5]; // ctrl, middle, active, bottom, unmapped
   logic [31:0] rd;
   logic [31:0] wd;
   logic [31:0] be;
   page_t pg;
   int op;
   int sel;
   sfr_page_context_stack dut (
      .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq_entry(irq_entry), .irq_page(irq_page),
      .irq_return(irq_return), .active_page(active_page), .auto_paging(auto_paging)
   );
   core_irq_model far (
      .clk(clk), .irq_entry(irq_entry), .irq_page(irq_page), .irq_return(irq_return)
   );
   // ************************************************************
   // expectation functions
   // ************************************************************
   // push wins over a pop in the same cycle
   function automatic void exp_event(input logic e, input logic r, input page_t p);
      page_t a;
      page_t m;
      a = e_act;
      m = e_mid;
      if (e) begin
         e_bot = m;
         e_mid = a;
         if (e_auto) begin
            e_act = p;
         end
      end else if (r) begin
         e_act = m;
         e_mid = e_bot;
      end
   endfunction
   // lane 0 disabled means the write is dropped
   function automatic void exp_write(input int i, input logic [31:0] d, input logic [3:0] b);
      if (b[0]) begin
         case (i)
            0: e_auto = d[0];
            1: e_mid = d[7:0];
            2: e_act = d[7:0];
            3: e_bot = d[7:0];
            default: ;
         endcase
      end
   endfunction
   // ************************************************************
   // bus, compare and closing tasks
   // ************************************************************
   task automatic report_and_stop();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
         input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      byteenable <= b;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) begin
         fail_count++;
         report_and_stop();
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   // reads every entry; the reads themselves must not shift anything
   task automatic check_all();
      bus(1'b0, reg_addr[3], 32'h0000_0000, 4'hF, rd);
      check("bottom entry", rd, {24'h0, e_bot});
      bus(1'b0, reg_addr[1], 32'h0000_0000, 4'hF, rd);
      check("middle entry", rd, {24'h0, e_mid});
      bus(1'b0, reg_addr[2], 32'h0000_0000, 4'hF, rd);
      check("active entry", rd, {24'h0, e_act});
      bus(1'b0, reg_addr[0], 32'h0000_0000, 4'hF, rd);
      check("paging control", rd, {31'h0, e_auto});
      check("active page port", {24'h0, active_page}, {24'h0, e_act});
      check("auto paging port", {31'h0, auto_paging}, {31'h0, e_auto});
   endtask
   // ************************************************************
   // clock and main sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = '0;
      writedata = '0;
      byteenable = '0;
      fail_count = 0;
      n_compared = 0;
      e_act = 8'h00;
      e_mid = 8'h00;
      e_bot = 8'h00;
      e_auto = 1'b1;
      reg_addr = '{{`REG_IDX_CTRL, 2'b00}, {`REG_IDX_MIDDLE, 2'b00},
         {`REG_IDX_ACTIVE, 2'b00}, {`REG_IDX_BOTTOM, 2'b00}, {8'h86, 2'b00}};
      void'($urandom(14));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      check_all();
      // every bit of the bottom entry holds a one, then a second bottom value drops to middle on a return
      bus(1'b1, reg_addr[3], 32'hFFFF_FFFF, 4'hF, rd);
      exp_write(3, 32'hFFFF_FFFF, 4'hF);
      check_all();
      bus(1'b1, reg_addr[3], 32'h0000_003C, 4'hF, rd);
      exp_write(3, 32'h0000_003C, 4'hF);
      far.pulse(1'b0, 1'b1, 8'h00);
      exp_event(1'b0, 1'b1, 8'h00);
      bus(1'b0, reg_addr[1], 32'h0000_0000, 4'hF, rd);
      check("bottom reaches middle", rd, 32'h0000_003C);
      check_all();
      bus(1'b0, reg_addr[4], 32'h0000_0000, 4'hF, rd);
      check("unmapped read", rd, 32'h0000_0000);
      // two pushes one quiet cycle apart carry the top entry to the bottom
      far.pulse(1'b1, 1'b0, 8'h11);
      exp_event(1'b1, 1'b0, 8'h11);
      far.pulse(1'b1, 1'b0, 8'h22);
      exp_event(1'b1, 1'b0, 8'h22);
      check_all();
      // with auto paging off an entry keeps the active page
      bus(1'b1, reg_addr[0], 32'h0000_0000, 4'hF, rd);
      exp_write(0, 32'h0000_0000, 4'hF);
      far.pulse(1'b1, 1'b0, 8'h33);
      exp_event(1'b1, 1'b0, 8'h33);
      check_all();
      bus(1'b1, reg_addr[0], 32'h0000_0001, 4'hF, rd);
      exp_write(0, 32'h0000_0001, 4'hF);
      // random mix of entries, returns, collisions and writes
      for (int k = 0; k < 80; k++) begin
         op = $urandom_range(0, 3);
         pg = page_t'($urandom);
         if (op < 3) begin
            far.pulse(op != 1, op != 0, pg);
            exp_event(op != 1, op != 0, pg);
         end else begin
            sel = $urandom_range(0, 4);
            wd = $urandom;
            be = $urandom;
            bus(1'b1, reg_addr[sel], wd, be[3:0], rd);
            exp_write(sel, wd, be[3:0]);
         end
         check_all();
      end
      // a reset in mid-run clears every entry and sets auto paging again
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      e_act = 8'h00;
      e_mid = 8'h00;
      e_bot = 8'h00;
      e_auto = 1'b1;
      check_all();
      report_and_stop();
   end
endmodule // sfr_page_context_stack_bench
